//--- hdl/hds_pkg.sv
// Package for the halt and debug status block: map, fields, codes and carriers
package hds_pkg;
  localparam logic [7:0] HDS_STATUS_OFS  = 8'h00;
  localparam logic [7:0] HDS_CONTROL_OFS = 8'h04;
  localparam logic [7:0] HDS_RAMPORT_OFS = 8'h08;
  // Status and control fields, MSB-first bit n of the register sits at index 31-n
  localparam int HDS_HS_POS    = 31;
  localparam int HDS_HC_POS    = 28;
  localparam int HDS_HCP_POS   = 27;
  localparam int HDS_RIP_POS   = 26;
  localparam int HDS_SIP_POS   = 25;
  localparam int HDS_TRAP_POS  = 24;
  localparam int HDS_IAC_POS   = 23;
  localparam int HDS_BRC_POS   = 20;
  localparam int HDS_LDAC_POS  = 19;
  localparam int HDS_STAC_POS  = 18;
  localparam int HDS_WS_POS    = 17;
  localparam int HDS_TRH_POS   = 16;
  localparam int HDS_SEQ_POS   = 12;
  localparam int HDS_LP_POS    = 11;
  localparam int HDS_EP_POS    = 10;
  localparam int HDS_EE_POS    = 9;
  localparam int HDS_CMD_POS   = 28;
  localparam logic [31:0] HDS_RESET_WORD = 32'h0000_0000;
  localparam logic [2:0] HDS_CMD_CLEAR  = 3'h0;
  localparam logic [2:0] HDS_CMD_HALT   = 3'h1;
  localparam logic [2:0] HDS_CMD_RESUME = 3'h2;
  localparam logic [2:0] HDS_CMD_STEP   = 3'h3;
  localparam logic [2:0] HDS_CMD_TRH    = 3'h4;
  localparam logic [2:0] HDS_CMD_FORCE  = 3'h7;
  localparam logic [2:0] HDS_HC_NONE    = 3'h0;
  localparam logic [2:0] HDS_HC_FORCE   = 3'h1;
  localparam logic [2:0] HDS_HC_WDT     = 3'h2;
  localparam logic [2:0] HDS_HC_UNMASK  = 3'h3;
  localparam logic [2:0] HDS_HC_DEBUG   = 3'h4;
  localparam logic [2:0] HDS_HC_DBCTL   = 3'h5;
  localparam logic [2:0] HDS_HC_HALTREQ = 3'h6;
  localparam logic [2:0] HDS_HC_HWFAIL  = 3'h7;

  typedef struct packed {
    logic        busy;
    logic        inst_done;
    logic        int_taken;
    logic        wdt_halt;
    logic        dbctl_halt;
    logic        hw_fail;
    logic        mcheck_int;
    logic        prog_int;
    logic        istor_int;
    logic        dstor_int;
    logic        align_int;
    logic        machine_check_enable;
    logic        unmaskable_halt_enable;
    logic        wait_enable;
    logic        external_interrupt_enable;
    logic        low_priority;
    logic [2:0]  bus_return_code;
    logic        maskable_event_pending;
    logic        trap_exec;
    logic        trap_enable;
    logic        inst_compare_enable;
    logic [1:0]  data_compare_enable;
    logic        zero_address_compare_enable;
    logic        halt_freeze_pending;
    logic [31:0] address_compare_value;
    logic        fetch_valid;
    logic [31:0] instruction_address;
    logic        data_valid;
    logic        data_is_load;
    logic [31:0] data_address;
    logic [3:0]  sequencer_state;
  } hds_core_in_t;

  typedef struct packed {
    logic        halted_state;
    logic        halt_pending;
    logic        step_start;
    logic        ram_start;
    logic [31:0] ram_inst;
    logic        force_halt;
    logic        freeze_timers;
    logic        debug_halt;
  } hds_core_out_t;
endpackage : hds_pkg

//--- hdl/hds_halt_debug_status.sv
// Halt and debug status logic with APB register access
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
module hds_halt_debug_status
  import hds_pkg::*;
#(
  parameter bit EXTENDED = 1'b1
) (
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          core_reset,
  input  wire logic          halt_req_pin,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire hds_core_in_t  core_in,
  output hds_core_out_t      core_out
);

  typedef struct packed {
    logic [1:0]  hreq_sync;
    logic [2:0]  halt_cause;
    logic        halt_pending;
    logic        halted;
    logic        ram_active;
    logic        step_active;
    logic        trap_ev;
    logic        iac_ev;
    logic        ldac_ev;
    logic        stac_ev;
    logic        timers_run_halted;
    logic        ep_mirror;
    logic        step_start;
    logic        ram_start;
    logic        force_halt;
    logic        debug_halt;
    logic [31:0] ram_inst;
    logic [31:0] rdata;
    logic        err;
  } hds_state_t;

  hds_state_t st_r;
  hds_state_t st_nxt;

  logic        wr_acc;
  logic        setup;
  logic        mapped;
  logic [2:0]  cmd;
  logic        cmd_wr;
  logic        ram_wr;
  logic        unmask_src;
  logic        cmp_on;
  logic        iac_hit;
  logic        ldac_hit;
  logic        stac_hit;
  logic        trap_hit;
  logic        debug_src;
  logic [2:0]  src_code;
  logic        any_src;
  logic        clr_cause;
  logic [31:0] status_word;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == HDS_STATUS_OFS) || (a == HDS_CONTROL_OFS) || (a == HDS_RAMPORT_OFS);
  endfunction : is_mapped

  // Highest code wins when several sources arrive together
  function automatic logic [2:0] pick_cause(input logic [7:0] s);
    logic [2:0] c;
    c = HDS_HC_NONE;
    for (int i = 1; i < 8; i++) begin
      if (s[i]) begin
        c = 3'(i);
      end
    end
    return c;
  endfunction : pick_cause

  always_comb begin
    setup  = psel && !penable;
    mapped = is_mapped(paddr);
    wr_acc = psel && penable && pwrite && mapped;
    cmd    = pwdata[HDS_CMD_POS +: 3];
    cmd_wr = wr_acc && (paddr == HDS_CONTROL_OFS);
    ram_wr = wr_acc && (paddr == HDS_RAMPORT_OFS) && st_r.halted;
    unmask_src = (core_in.mcheck_int && !core_in.machine_check_enable)
               || ((core_in.prog_int || core_in.istor_int || core_in.dstor_int
                    || core_in.align_int)
                   && !core_in.unmaskable_halt_enable
                   && !core_in.machine_check_enable);
    cmp_on   = !st_r.ram_active;
    iac_hit  = cmp_on && core_in.inst_compare_enable && core_in.fetch_valid
             && (core_in.instruction_address == core_in.address_compare_value);
    ldac_hit = cmp_on && core_in.data_valid && core_in.data_is_load
             && ((core_in.data_compare_enable[1]
                  && core_in.data_address == core_in.address_compare_value)
                 || (core_in.zero_address_compare_enable
                     && core_in.data_address == 32'h0000_0000));
    stac_hit = cmp_on && core_in.data_valid && !core_in.data_is_load
             && ((core_in.data_compare_enable[0]
                  && core_in.data_address == core_in.address_compare_value)
                 || (core_in.zero_address_compare_enable
                     && core_in.data_address == 32'h0000_0000));
    trap_hit  = core_in.trap_exec && core_in.trap_enable;
    debug_src = trap_hit || iac_hit || ldac_hit || stac_hit;
    src_code  = pick_cause({core_in.hw_fail, st_r.hreq_sync[1], core_in.dbctl_halt,
                            debug_src, unmask_src, core_in.wdt_halt,
                            cmd_wr && (cmd == HDS_CMD_FORCE), 1'b0});
    any_src   = (src_code != HDS_HC_NONE) || (cmd_wr && (cmd == HDS_CMD_HALT));
    clr_cause = ram_wr
              || (cmd_wr && (cmd == HDS_CMD_RESUME))
              || (cmd_wr && (cmd == HDS_CMD_STEP) && st_r.halted);
  end

  always_comb begin
    status_word = HDS_RESET_WORD;
    status_word[HDS_HS_POS]        = st_r.halted;
    status_word[HDS_HC_POS +: 3]   = st_r.halt_cause;
    status_word[HDS_HCP_POS]       = st_r.halt_pending;
    status_word[HDS_RIP_POS]       = st_r.ram_active;
    status_word[HDS_SIP_POS]       = st_r.step_active;
    status_word[HDS_TRAP_POS]      = st_r.trap_ev;
    status_word[HDS_IAC_POS]       = st_r.iac_ev;
    status_word[HDS_BRC_POS +: 3]  = core_in.bus_return_code;
    status_word[HDS_LDAC_POS]      = st_r.ldac_ev;
    status_word[HDS_STAC_POS]      = st_r.stac_ev;
    status_word[HDS_WS_POS]        = core_in.wait_enable;
    status_word[HDS_TRH_POS]       = st_r.timers_run_halted;
    status_word[HDS_SEQ_POS +: 4]  = core_in.sequencer_state;
    status_word[HDS_LP_POS]        = core_in.low_priority;
    status_word[HDS_EP_POS]        = st_r.ep_mirror;
    status_word[HDS_EE_POS]        = EXTENDED && core_in.external_interrupt_enable;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.hreq_sync  = {st_r.hreq_sync[0], halt_req_pin};
    st_nxt.step_start = 1'b0;
    st_nxt.ram_start  = 1'b0;
    st_nxt.force_halt = 1'b0;
    st_nxt.debug_halt = debug_src;

    // Clear first so a same-cycle source below still records
    if (clr_cause) begin
      st_nxt.halt_cause = HDS_HC_NONE;
    end
    if (st_nxt.halt_cause == HDS_HC_NONE) begin
      st_nxt.halt_cause = src_code;
    end

    if (st_r.ram_active && core_in.inst_done) begin
      st_nxt.ram_active = 1'b0;
    end
    if (st_r.step_active && (core_in.inst_done || core_in.int_taken)) begin
      st_nxt.step_active = 1'b0;
    end

    if (cmd_wr) begin
      case (cmd)
        HDS_CMD_CLEAR: begin
          if (st_r.halted) begin
            st_nxt.trap_ev = 1'b0;
            st_nxt.iac_ev  = 1'b0;
            st_nxt.ldac_ev = 1'b0;
            st_nxt.stac_ev = 1'b0;
          end
        end
        HDS_CMD_RESUME: begin
          st_nxt.halt_pending = 1'b0;
        end
        HDS_CMD_STEP: begin
          if (st_r.halted) begin
            st_nxt.step_active = 1'b1;
            st_nxt.step_start  = 1'b1;
          end
        end
        HDS_CMD_TRH: begin
          st_nxt.timers_run_halted = !st_r.timers_run_halted;
        end
        HDS_CMD_FORCE: begin
          st_nxt.step_active = 1'b0;
          st_nxt.ram_active  = 1'b0;
          st_nxt.force_halt  = 1'b1;
        end
        default: begin
        end
      endcase
    end

    if (ram_wr) begin
      st_nxt.ram_active = 1'b1;
      st_nxt.ram_start  = 1'b1;
      st_nxt.ram_inst   = pwdata;
    end

    // Event bits set after the clear so a new event is lost only to a same-cycle core_reset or srst
    if (trap_hit) begin
      st_nxt.trap_ev = 1'b1;
    end
    if (iac_hit) begin
      st_nxt.iac_ev = 1'b1;
    end
    if (ldac_hit) begin
      st_nxt.ldac_ev = 1'b1;
    end
    if (stac_hit) begin
      st_nxt.stac_ev = 1'b1;
    end
    if (any_src) begin
      st_nxt.halt_pending = 1'b1;
    end

    // Halt only once nothing is executing; a force halt skips the drain.
    // An already halted core stays halted so a forced halt outlives its pulse.
    st_nxt.halted = st_nxt.halt_pending
                  && (!core_in.busy || st_nxt.force_halt || st_r.halted)
                  && !st_nxt.step_active
                  && !st_nxt.ram_active
                  && !st_nxt.step_start
                  && !st_nxt.ram_start;

    if (!(EXTENDED && (st_r.halt_cause > HDS_HC_FORCE) && core_in.halt_freeze_pending)) begin
      st_nxt.ep_mirror = core_in.maskable_event_pending;
    end

    if (setup) begin
      st_nxt.rdata = (paddr == HDS_STATUS_OFS) ? status_word : 32'h0000_0000;
      st_nxt.err   = !mapped;
    end

    if (core_reset) begin
      st_nxt.halt_cause   = HDS_HC_NONE;
      st_nxt.halt_pending = 1'b0;
      st_nxt.halted       = 1'b0;
      st_nxt.ram_active   = 1'b0;
      st_nxt.step_active  = 1'b0;
      st_nxt.trap_ev      = 1'b0;
      st_nxt.iac_ev       = 1'b0;
      st_nxt.ldac_ev      = 1'b0;
      st_nxt.stac_ev      = 1'b0;
      st_nxt.step_start   = 1'b0;
      st_nxt.ram_start    = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Data is captured in setup, so every access completes in one access cycle
  assign pready  = psel && penable;
  assign prdata  = st_r.rdata;
  assign pslverr = psel && penable && st_r.err;

  always_comb begin
    core_out.halted_state  = st_r.halted;
    core_out.halt_pending  = st_r.halt_pending;
    core_out.step_start    = st_r.step_start;
    core_out.ram_start     = st_r.ram_start;
    core_out.ram_inst      = st_r.ram_inst;
    core_out.force_halt    = st_r.force_halt;
    core_out.debug_halt    = st_r.debug_halt;
    core_out.freeze_timers = st_r.halt_pending && !st_r.timers_run_halted;
  end

  a_halted_pending: assert property (@(posedge clock) disable iff (srst || core_reset)
    st_r.halted |-> st_r.halt_pending)
    else $error("halted without pending halt");
  a_exec_not_halted: assert property (@(posedge clock) disable iff (srst || core_reset)
    (st_r.step_active || st_r.ram_active) |-> !st_r.halted)
    else $error("halted while stepping or ramming");
  a_force_cause: assert property (@(posedge clock) disable iff (srst || core_reset)
    (src_code == HDS_HC_FORCE && st_r.halt_cause == HDS_HC_NONE && !clr_cause)
    |=> (st_r.halt_cause == HDS_HC_FORCE) && st_r.halt_pending)
    else $error("force halt did not record cause 001");
  a_cause_hold: assert property (@(posedge clock) disable iff (srst || core_reset)
    (st_r.halt_cause != HDS_HC_NONE && !clr_cause) |=> $stable(st_r.halt_cause))
    else $error("halt cause overwritten");
  a_resume_clears: assert property (@(posedge clock) disable iff (srst || core_reset)
    (cmd_wr && cmd == HDS_CMD_RESUME && src_code == HDS_HC_NONE)
    |=> st_r.halt_cause == HDS_HC_NONE)
    else $error("resume did not clear cause");
  a_trh_toggle: assert property (@(posedge clock) disable iff (srst)
    (cmd_wr && cmd == HDS_CMD_TRH) |=> st_r.timers_run_halted != $past(st_r.timers_run_halted))
    else $error("timers-run-halted did not toggle");
  a_trh_only_cmd: assert property (@(posedge clock) disable iff (srst)
    !(cmd_wr && cmd == HDS_CMD_TRH) |=> $stable(st_r.timers_run_halted))
    else $error("timers-run-halted changed without command");
  a_ram_starts: assert property (@(posedge clock) disable iff (srst || core_reset)
    ram_wr |=> st_r.ram_active && st_r.ram_start ##1 !st_r.ram_start)
    else $error("ramming did not start");
  a_step_starts: assert property (@(posedge clock) disable iff (srst || core_reset)
    (cmd_wr && cmd == HDS_CMD_STEP && st_r.halted) |=> st_r.step_active && !st_r.halted)
    else $error("step did not start");
  a_no_cmp_ram: assert property (@(posedge clock) disable iff (srst)
    st_r.ram_active |-> !(iac_hit || ldac_hit || stac_hit))
    else $error("address compare applied while ramming");
  a_timer_freeze: assert property (@(posedge clock) disable iff (srst)
    (st_r.halt_pending && !st_r.timers_run_halted) |-> core_out.freeze_timers)
    else $error("timers not frozen while halt pending");
  a_ee_reserved: assert property (@(posedge clock) disable iff (srst)
    !EXTENDED |-> !status_word[HDS_EE_POS])
    else $error("reserved bit set in base variant");

  c_halt_resume: cover property (@(posedge clock) disable iff (srst)
    st_r.halted ##1 (cmd_wr && cmd == HDS_CMD_RESUME) ##[1:4] !st_r.halted);
  c_step: cover property (@(posedge clock) disable iff (srst)
    st_r.step_active ##[1:20] st_r.halted);
  c_ram: cover property (@(posedge clock) disable iff (srst)
    st_r.ram_active ##[1:20] st_r.halted);
  c_debug_halt: cover property (@(posedge clock) disable iff (srst)
    st_r.halt_cause == HDS_HC_DEBUG && st_r.halted);

endmodule : hds_halt_debug_status

//--- dv/hds_core_model.sv
// Behavioural core: runs stepped and rammed instructions for a set number of cycles
`timescale 1ns/10ps
module hds_core_model
  import hds_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic [3:0]    exec_len,
  input  wire hds_core_in_t  stim,
  input  wire hds_core_out_t core_out,
  output hds_core_in_t       core_in
);
  logic [3:0] cnt_r;

  always_ff @(posedge clock) begin
    if (srst || core_out.force_halt) begin
      cnt_r <= 4'h0;
    end else if (core_out.step_start || core_out.ram_start) begin
      cnt_r <= exec_len;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Busy stays up through the done cycle, so the block must wait for it to drop
  always_comb begin
    core_in           = stim;
    core_in.busy      = stim.busy | (cnt_r != 4'h0);
    core_in.inst_done = stim.inst_done | (cnt_r == 4'h1);
  end
endmodule : hds_core_model

//--- dv/tb_hds_halt_debug_status.sv
// Self-checking bench for the halt and debug status block
`timescale 1ns/10ps
module tb_hds_halt_debug_status
  import hds_pkg::*;
;
  `define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

  localparam logic [31:0] MIR = 32'h0052_AE00;
  localparam logic [31:0] EVM = 32'h018C_0000;
  localparam logic [2:0]  EXP_HC [11] = '{HDS_HC_WDT, HDS_HC_UNMASK, HDS_HC_DBCTL,
    HDS_HC_HWFAIL, HDS_HC_HALTREQ, HDS_HC_DEBUG, HDS_HC_DEBUG, HDS_HC_DEBUG, HDS_HC_DEBUG,
    HDS_HC_DEBUG, HDS_HC_UNMASK};
  localparam logic [31:0] EXP_EV [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0100_0000,
    32'h0080_0000, 32'h0008_0000, 32'h0004_0000, 32'h0004_0000, 32'h0};

  logic          clock, srst, core_reset, halt_req_pin;
  logic          psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdata;
  hds_core_in_t  stim, base, core_in;
  hds_core_out_t core_out;
  int            error_cnt;
  int            cmp_count;

  hds_halt_debug_status #(.EXTENDED(1'b1)) i_hds_halt_debug_status (
    .clock(clock), .srst(srst), .core_reset(core_reset), .halt_req_pin(halt_req_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_in(core_in),
    .core_out(core_out));

  hds_core_model i_hds_core_model (
    .clock(clock), .srst(srst), .exec_len(4'h6), .stim(stim), .core_out(core_out),
    .core_in(core_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_st;
    apb(1'b0, HDS_STATUS_OFS, 32'h0);
  endtask : rd_st

  task automatic cmd(input logic [2:0] c);
    apb(1'b1, HDS_CONTROL_OFS, 32'(c) << HDS_CMD_POS);
  endtask : cmd

  // Software learns completion only by polling the halted bit
  task automatic wait_hs(input logic ex);
    int n;
    n = 0;
    do begin
      rd_st();
      n++;
    end while (rdata[HDS_HS_POS] !== ex && n < 20);
  endtask : wait_hs

  function automatic logic [4:0] hph(input logic [31:0] s);
    return {s[HDS_HS_POS], s[HDS_HCP_POS], s[HDS_HC_POS+:3]};
  endfunction : hph

  task automatic fire(input int k);
    hds_core_in_t s;
    s = base;
    case (k)
      0: s.wdt_halt = 1'b1;
      1: s.mcheck_int = 1'b1;
      2: s.dbctl_halt = 1'b1;
      3: s.hw_fail = 1'b1;
      5: s.trap_exec = 1'b1;
      6: s.fetch_valid = 1'b1;
      7: {s.data_valid, s.data_is_load} = 2'h3;
      8: s.data_valid = 1'b1;
      9: {s.data_valid, s.data_address} = {1'b1, 32'h0};
      10: s.prog_int = 1'b1;
      default: ;
    endcase
    @(posedge clock);
    stim <= s;
    halt_req_pin <= (k == 4);
    repeat (4) @(posedge clock);
    stim <= base;
    halt_req_pin <= 1'b0;
  endtask : fire

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("ERROR watchdog expired");
    final_report();
  end

  initial begin
    base = '0;
    base.trap_enable = 1'b1;
    base.inst_compare_enable = 1'b1;
    base.data_compare_enable = 2'h3;
    base.zero_address_compare_enable = 1'b1;
    base.address_compare_value = 32'h0000_1234;
    base.instruction_address = 32'h0000_1234;
    base.data_address = 32'h0000_1234;
    base.wait_enable = 1'b1;
    base.bus_return_code = 3'h5;
    base.low_priority = 1'b1;
    base.maskable_event_pending = 1'b1;
    base.external_interrupt_enable = 1'b1;
    base.halt_freeze_pending = 1'b1;
    base.sequencer_state = 4'hA;
    {srst, core_reset, halt_req_pin, psel, penable, pwrite} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    stim = base;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rd_st();
    `CHK("status", MIR, rdata)
    apb(1'b1, HDS_STATUS_OFS, 32'hFFFF_FFFF);
    rd_st();
    `CHK("status ro", MIR, rdata)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {rerr, rdata})
    stim.busy <= 1'b1;
    cmd(HDS_CMD_HALT);
    rd_st();
    `CHK("draining", 5'h08, hph(rdata))
    stim.busy <= 1'b0;
    wait_hs(1'b1);
    `CHK("halted", 5'h18, hph(rdata))
    `CHK("halted out", 1'b1, core_out.halted_state)
    cmd(HDS_CMD_STEP);
    rd_st();
    `CHK("stepping", 3'h3, {rdata[HDS_HS_POS], rdata[HDS_SIP_POS], rdata[HDS_HCP_POS]})
    wait_hs(1'b1);
    `CHK("stepped", 6'h18, {rdata[HDS_SIP_POS], hph(rdata)})
    apb(1'b1, HDS_RAMPORT_OFS, 32'hC0DE_0042);
    rd_st();
    `CHK("ramming", 2'h1, {rdata[HDS_HS_POS], rdata[HDS_RIP_POS]})
    `CHK("ram word", 32'hC0DE_0042, core_out.ram_inst)
    wait_hs(1'b1);
    `CHK("rammed", 6'h18, {rdata[HDS_RIP_POS], hph(rdata)})
    cmd(HDS_CMD_TRH);
    rd_st();
    `CHK("trh", 2'h2, {rdata[HDS_TRH_POS], core_out.freeze_timers})
    cmd(HDS_CMD_TRH);
    rd_st();
    `CHK("trh", 2'h1, {rdata[HDS_TRH_POS], core_out.freeze_timers})
    cmd(HDS_CMD_RESUME);
    rd_st();
    `CHK("resumed", 5'h00, hph(rdata))
    stim.busy <= 1'b1;
    cmd(HDS_CMD_FORCE);
    rd_st();
    `CHK("forced", 5'h19, hph(rdata))
    stim.busy <= 1'b0;
    cmd(HDS_CMD_RESUME);
    for (int k = 0; k < 11; k++) begin
      fire(k);
      wait_hs(1'b1);
      `CHK("cause", EXP_HC[k], rdata[HDS_HC_POS+:3])
      `CHK("events", EXP_EV[k], rdata & EVM)
      `CHK("freeze", 1'b1, core_out.freeze_timers)
      if (k == 4) begin
        cmd(HDS_CMD_FORCE);
        stim.maskable_event_pending <= 1'b0;
        rd_st();
        `CHK("cause held", HDS_HC_HALTREQ, rdata[HDS_HC_POS+:3])
        `CHK("ep frozen", 1'b1, rdata[HDS_EP_POS])
        stim.maskable_event_pending <= 1'b1;
      end
      cmd(HDS_CMD_CLEAR);
      rd_st();
      `CHK("events clr", 32'h0, rdata & EVM)
      cmd(HDS_CMD_RESUME);
      rd_st();
      `CHK("resumed", 5'h00, hph(rdata))
    end
    cmd(HDS_CMD_FORCE);
    core_reset <= 1'b1;
    repeat (2) @(posedge clock);
    core_reset <= 1'b0;
    rd_st();
    `CHK("core reset", 5'h00, hph(rdata))
    `CHK("status", MIR, rdata)
    final_report();
  end
endmodule : tb_hds_halt_debug_status
